// file: src/mcx_regs.vh
`ifndef MCX_REGS_VH
`define MCX_REGS_VH
// register byte offsets
`define MCX_OFS_INSTR 8'h00
`define MCX_OFS_STATUS 8'h04
`define MCX_OFS_FLAGS 8'h08
`define MCX_OFS_PC 8'h0c
`define MCX_OFS_BD_ADDR 8'h10
`define MCX_OFS_BD_DATA 8'h14
`define MCX_OFS_STATE 8'h18
`define MCX_OFS_WDEST 8'h20
`define MCX_OFS_ALU 8'h40
// spacing between consecutive table or register-file words
`define MCX_STRIDE 8'h04
// number of words in the operand register file
`define MCX_NALU 8
// flag bit positions in the condition register
`define MCX_F_ZERO 0
`define MCX_F_NEG 1
`define MCX_F_UU 2
`define MCX_F_UO 3
`define MCX_F_SU 4
`define MCX_F_SO 5
`define MCX_F_CS 6
// opcode patterns
`define MCX_OP_STSRB 11'h1b8
`define MCX_OP_SUB 6'h0a
`define MCX_OP_SUBI 6'h07
`define MCX_OP_SWAP 13'h06ac
`define MCX_OP_INT_TO_TWOS_COMP_INSTR 13'h06e6
`define MCX_OP_TOINT 12'h372
`define MCX_OP_WAIT 11'h1a8
`define MCX_OP_WRSPI 16'h3541
`endif

// file: src/mcx_exec.v
// Design decisions made here: the placing of the registers and register access over Avalon-MM.
`timescale 1ns/1ps
`include "mcx_regs.vh"
module mcx_exec #(
  parameter DW = 16,
  parameter PCW = 10,
  parameter ROWS = 5
) (
  input wire clk,
  input wire rst_b,
  input wire [7:0] avs_address,
  input wire avs_read,
  input wire avs_write,
  input wire [31:0] avs_writedata,
  input wire [3:0] avs_byteenable,
  output reg [31:0] avs_readdata,
  output wire avs_waitrequest,
  input wire [ROWS-1:0] wait_cond_in,
  output wire [DW-1:0] status_bits,
  output wire [PCW-1:0] micro_program_counter,
  output reg bd_wr_strobe,
  output reg [DW-1:0] bd_wr_addr,
  output reg [DW-1:0] bd_wr_data
);
  // one-hot execution states
  localparam ST_IDLE = 3'b001;
  localparam ST_WAIT = 3'b010;
  localparam ST_BDWR = 3'b100;

  reg [2:0] state_reg;
  reg [DW-1:0] status_reg;
  reg [6:0] flags_reg;
  reg [PCW-1:0] pc_reg;
  reg [DW-1:0] bd_addr_reg;
  reg [DW-1:0] bd_data_reg;
  reg [ROWS-1:0] wait_rows_reg;
  reg [PCW-1:0] wdest_reg [0:ROWS-1];
  reg [DW-1:0] alu_reg [0:7];
  reg [ROWS-1:0] cond_meta_reg;
  reg [ROWS-1:0] cond_sync_reg;
  reg rd_ack_reg;
  // one loop variable per process, so that no variable has two drivers
  integer hi;
  integer ri;
  integer wi;

  assign status_bits = status_reg;
  assign micro_program_counter = pc_reg;

  // bus decode; a new instruction stalls until the previous one is done
  // of the writes, only one to the instruction word can stall; every other register
  // write is taken at once, even while a wait or a backdoor write is active,
  // so software can always abort a wait by loading the program counter.
  // reads always take one stall cycle, because read data comes from a flop
  // and is loaded in the first cycle of the request.
  wire sel_instr = (avs_address == `MCX_OFS_INSTR);
  wire busy = (state_reg != ST_IDLE);
  assign avs_waitrequest = (avs_read & ~rd_ack_reg) | (avs_write & sel_instr & busy);
  wire wr_go = avs_write & ~avs_waitrequest;
  wire [15:0] wd = avs_writedata[15:0];
  wire exec = wr_go & sel_instr;

  // instruction fields at fixed positions
  // every field is cut from the word unconditionally; only the opcode
  // compare below decides which of them means anything. this keeps the
  // decoder flat: one compare per instruction, no nested field decode.
  // the fields overlap on purpose, e.g. the immediate shares bits with the
  // second source index, exactly as the two encodings lay them out.
  wire [2:0] f_op1 = wd[2:0];
  wire [2:0] f_op2 = wd[5:3];
  wire [2:0] f_res = wd[9:7];
  wire [3:0] f_imm = wd[6:3];
  wire [3:0] status_bit_select = wd[3:0];
  wire f_level = wd[4];
  wire f_rst = wd[3];
  wire [ROWS-1:0] wait_row_enables = wd[ROWS-1:0];

  // opcode match per instruction; an unknown word only steps the counter.
  // the compare widths differ because the operand fields differ in size:
  // the fixed part of each word is matched, the operand part is ignored.
  wire is_stsrb = (wd[15:5] == `MCX_OP_STSRB);
  wire is_sub = (wd[15:10] == `MCX_OP_SUB) && wd[6];
  wire is_subi = (wd[15:10] == `MCX_OP_SUBI);
  wire is_swap = (wd[15:3] == `MCX_OP_SWAP);
  wire int_to_twos_comp_instr = (wd[15:3] == `MCX_OP_INT_TO_TWOS_COMP_INSTR);
  wire is_toint = (wd[15:4] == `MCX_OP_TOINT);
  wire is_wait = (wd[15:5] == `MCX_OP_WAIT);
  wire is_wrspi = (wd == `MCX_OP_WRSPI);

  // shared subtractor for both subtract forms
  // one extra bit on top of the difference gives the borrow, which is the
  // unsigned underflow. the signed flags come from the three sign bits:
  // a negative minuend minus a positive subtrahend that lands positive
  // wrapped below the signed range, and the mirror case wrapped above it.
  // a subtraction can never exceed the unsigned range, so that flag is
  // always written low; a user must not treat it as meaningful here.
  wire [DW-1:0] alu_operand_set = alu_reg[f_op1];
  wire [DW-1:0] sub_b = is_subi ? {{(DW-4){1'b0}}, f_imm} : alu_reg[f_op2];
  wire [DW:0] diff = {1'b0, alu_operand_set} - {1'b0, sub_b};
  wire [DW-1:0] res = diff[DW-1:0];
  wire a_s = alu_operand_set[DW-1];
  wire b_s = sub_b[DW-1];
  wire r_s = res[DW-1];

  // conversions
  // both directions negate only the low fifteen bits; the sign bit is
  // carried separately in the conversion sign flag, so a value converted
  // one way and back again keeps its magnitude. the negation of zero is
  // zero, so a negative zero becomes a plain zero with the sign kept.
  wire [DW-2:0] neg_low = ~alu_operand_set[DW-2:0] + {{(DW-2){1'b0}}, 1'b1};
  wire [DW-1:0] int_to_twos_comp_instr_val = flags_reg[`MCX_F_CS] ? {1'b1, neg_low}
                                                : {1'b0, alu_operand_set[DW-2:0]};
  wire [DW-1:0] toint_val = a_s ? {1'b0, neg_low} : alu_operand_set;

  // lowest enabled true row wins when several fire together
  // the rows are scanned from the top down so that the last assignment,
  // the lowest row that hits, is the one that stands. a fixed priority
  // was traded for simplicity: a row that is always true starves the rows
  // above it, which the program has to keep in mind when it picks masks.
  wire [ROWS-1:0] hit = wait_rows_reg & cond_sync_reg;
  reg [PCW-1:0] hit_dest;
  always @* begin
    hit_dest = {PCW{1'b0}};
    for (hi = ROWS-1; hi >= 0; hi = hi - 1) begin
      if (hit[hi]) begin
        hit_dest = wdest_reg[hi];
      end
    end
  end

  // condition pins come from outside the clock domain
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      cond_meta_reg <= {ROWS{1'b0}};
      cond_sync_reg <= {ROWS{1'b0}};
    end else begin
      cond_meta_reg <= wait_cond_in;
      cond_sync_reg <= cond_meta_reg;
    end
  end

  // read path: one stall cycle, then registered data
  // the data word is loaded in the stall cycle and then left alone, so it
  // stands at the accepting edge and until the next read. unmapped offsets
  // read as zero, and unused upper bits of every word read as zero too.
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      rd_ack_reg <= 1'b0;
      avs_readdata <= 32'h0000_0000;
    end else begin
      // the acknowledge toggles, so back-to-back reads each see one stall
      rd_ack_reg <= avs_read & ~rd_ack_reg;
      if (avs_read & ~rd_ack_reg) begin
        avs_readdata <= 32'h0000_0000;
        if (avs_address == `MCX_OFS_STATUS) avs_readdata[DW-1:0] <= status_reg;
        if (avs_address == `MCX_OFS_FLAGS) avs_readdata[6:0] <= flags_reg;
        if (avs_address == `MCX_OFS_PC) avs_readdata[PCW-1:0] <= pc_reg;
        if (avs_address == `MCX_OFS_BD_ADDR) avs_readdata[DW-1:0] <= bd_addr_reg;
        if (avs_address == `MCX_OFS_BD_DATA) avs_readdata[DW-1:0] <= bd_data_reg;
        if (avs_address == `MCX_OFS_STATE) avs_readdata[ROWS+2:0] <= {wait_rows_reg, state_reg};
        // wait table destinations, one word per row
        for (ri = 0; ri < ROWS; ri = ri + 1) begin
          if (avs_address == `MCX_OFS_WDEST + `MCX_STRIDE * ri[7:0])
            avs_readdata[PCW-1:0] <= wdest_reg[ri];
        end
        // operand register file, one word per register
        for (ri = 0; ri < `MCX_NALU; ri = ri + 1) begin
          if (avs_address == `MCX_OFS_ALU + `MCX_STRIDE * ri[7:0])
            avs_readdata[DW-1:0] <= alu_reg[ri];
        end
      end
    end
  end

  // instruction execution and register writes
  // one process owns every architectural register, so a bus write and an
  // instruction that touch the same register resolve by statement order:
  // the instruction comes later and wins. the counter write is last of all
  // so that software can always regain control of a stuck program.
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      state_reg <= ST_IDLE;
      status_reg <= {DW{1'b0}};
      flags_reg <= 7'h00;
      pc_reg <= {PCW{1'b0}};
      bd_addr_reg <= {DW{1'b0}};
      bd_data_reg <= {DW{1'b0}};
      wait_rows_reg <= {ROWS{1'b0}};
      bd_wr_strobe <= 1'b0;
      bd_wr_addr <= {DW{1'b0}};
      bd_wr_data <= {DW{1'b0}};
      for (wi = 0; wi < ROWS; wi = wi + 1) wdest_reg[wi] <= {PCW{1'b0}};
      for (wi = 0; wi < `MCX_NALU; wi = wi + 1) alu_reg[wi] <= {DW{1'b0}};
    end else begin
      bd_wr_strobe <= 1'b0;
      // plain data registers, low byte lanes only
      if (wr_go && avs_byteenable[1:0] == 2'b11) begin
        if (avs_address == `MCX_OFS_BD_ADDR) bd_addr_reg <= wd;
        if (avs_address == `MCX_OFS_BD_DATA) bd_data_reg <= wd;
        if (avs_address == `MCX_OFS_STATUS) status_reg <= wd;
        // wait table destinations keep only the counter width
        for (wi = 0; wi < ROWS; wi = wi + 1) begin
          if (avs_address == `MCX_OFS_WDEST + `MCX_STRIDE * wi[7:0]) begin
            wdest_reg[wi] <= wd[PCW-1:0];
          end
        end
        // operand register file
        for (wi = 0; wi < `MCX_NALU; wi = wi + 1) begin
          if (avs_address == `MCX_OFS_ALU + `MCX_STRIDE * wi[7:0]) alu_reg[wi] <= wd;
        end
      end
      // idle executes one word per accepted write; wait and backdoor states
      // hold off further instruction words through the stall on the bus
      case (state_reg)
        ST_IDLE: begin
          if (exec) begin
            pc_reg <= pc_reg + {{(PCW-1){1'b0}}, 1'b1};
            if (is_stsrb) begin
              status_reg[status_bit_select] <= f_level;
            end else if (is_sub || is_subi) begin
              alu_reg[f_res] <= res;
              flags_reg[`MCX_F_ZERO] <= (res == {DW{1'b0}});
              flags_reg[`MCX_F_NEG] <= r_s;
              flags_reg[`MCX_F_UU] <= diff[DW];
              flags_reg[`MCX_F_UO] <= 1'b0;
              flags_reg[`MCX_F_SU] <= a_s & ~b_s & ~r_s;
              flags_reg[`MCX_F_SO] <= ~a_s & b_s & r_s;
            end else if (is_swap) begin
              alu_reg[f_op1] <= {alu_operand_set[7:0], alu_operand_set[15:8]};
            end else if (int_to_twos_comp_instr) begin
              alu_reg[f_op1] <= int_to_twos_comp_instr_val;
            end else if (is_toint) begin
              alu_reg[f_op1] <= toint_val;
              flags_reg[`MCX_F_CS] <= f_rst ? a_s : (flags_reg[`MCX_F_CS] ^ a_s);
            end else if (is_wait) begin
              pc_reg <= pc_reg;
              wait_rows_reg <= wait_row_enables;
              state_reg <= ST_WAIT;
            end else if (is_wrspi) begin
              state_reg <= ST_BDWR;
            end
          end
        end
        ST_WAIT: begin
          // an empty mask never hits, so only a counter write frees it
          if (|hit) begin
            pc_reg <= hit_dest;
            state_reg <= ST_IDLE;
          end
        end
        // second cycle of the backdoor write: the address and data registers
        // are copied here, one cycle after the instruction was taken. this is
        // why a write to either register right after the instruction does not
        // spoil the transfer: it lands on this same edge, after the old values are copied.
        ST_BDWR: begin
          // sampled in the second cycle, before a write on that edge lands, so a change right after is safe
          bd_wr_strobe <= 1'b1;
          bd_wr_addr <= bd_addr_reg;
          bd_wr_data <= bd_data_reg;
          state_reg <= ST_IDLE;
        end
        default: begin
          state_reg <= ST_IDLE;
        end
      endcase
      // software counter write also aborts a pending wait
      if (wr_go && avs_address == `MCX_OFS_PC) begin
        pc_reg <= wd[PCW-1:0];
        if (state_reg == ST_WAIT) state_reg <= ST_IDLE;
      end
    end
  end
endmodule // mcx_exec

// file: tb/mcx_exec_properties.sv
`timescale 1ns/1ps
`include "mcx_regs.vh"
module mcx_exec_props #(
  parameter DW = 16,
  parameter PCW = 10
) (
  input wire clk,
  input wire rst_b,
  input wire [7:0] avs_address,
  input wire avs_write,
  input wire [31:0] avs_writedata,
  input wire avs_waitrequest,
  input wire [DW-1:0] status_bits,
  input wire [PCW-1:0] micro_program_counter,
  input wire bd_wr_strobe,
  input wire [DW-1:0] bd_wr_addr,
  input wire [DW-1:0] bd_wr_data
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_b);
  // instruction word taken this edge; only an idle core takes one
  wire acc = avs_write && !avs_waitrequest && avs_address == `MCX_OFS_INSTR;
  wire [15:0] wd = avs_writedata[15:0];
  a_strobe_pulse: assert property (bd_wr_strobe |=> !bd_wr_strobe) else $error("long");
  a_spi_launch: assert property (acc && wd == `MCX_OP_WRSPI |-> ##2 bd_wr_strobe)
    else $error("no strobe");
  a_strobe_cause: assert property ($rose(bd_wr_strobe) |-> $past(acc && wd == `MCX_OP_WRSPI, 2))
    else $error("stray strobe");
  a_bd_hold: assert property (!bd_wr_strobe |-> $stable({bd_wr_addr, bd_wr_data}))
    else $error("bd moved");
  a_pc_step: assert property (acc && wd[15:5] != `MCX_OP_WAIT |=>
    micro_program_counter == $past(micro_program_counter) + 1'b1) else $error("pc step");
  a_wait_stall: assert property (acc && wd[15:5] == `MCX_OP_WAIT |=>
    $stable(micro_program_counter)) else $error("pc moved");
  a_status_bit: assert property (acc && wd[15:5] == `MCX_OP_STSRB |=>
    status_bits[$past(wd[3:0])] == $past(wd[4])) else $error("bit level");
  a_status_keep: assert property (acc && wd[15:5] == `MCX_OP_STSRB |=>
    ((status_bits ^ $past(status_bits)) & ~(16'h1 << $past(wd[3:0]))) == 16'h0)
    else $error("other bits");
endmodule // mcx_exec_props

// file: tb/mcx_cond_src.sv
`timescale 1ns/1ps
// far-side condition sources behind the wait table rows
module mcx_cond_src (
  input wire clk,
  input wire [4:0] want,
  output reg [4:0] cond
);
  // launched after an edge, so the core must synchronise them
  always @(posedge clk) begin
    cond <= want;
  end
endmodule // mcx_cond_src

// file: tb/mcx_exec_tb.sv
`timescale 1ns/1ps
module mcx_exec_tb;
  reg clk = 1'b0;
  reg rst_b = 1'b0;
  reg [7:0] adr = 8'h00;
  reg rd = 1'b0;
  reg wr = 1'b0;
  reg [31:0] wdat = 32'h0;
  reg [4:0] want = 5'h0;
  wire [4:0] cond;
  wire [31:0] rdat;
  wire wreq, stb;
  wire [15:0] st, ba, bd;
  wire [9:0] pc;
  logic [31:0] q[$], bq[$];
  integer err_count = 0, n_checks = 0, i, k;
  reg [15:0] r1, r2, s, sm;
  reg [6:0] fl;
  reg [9:0] dst[0:4];
  always #2 clk = ~clk;
  mcx_cond_src src_u (.clk(clk), .want(want), .cond(cond));
  mcx_exec dut_u (.clk(clk), .rst_b(rst_b), .avs_address(adr), .avs_read(rd), .avs_write(wr),
    .avs_writedata(wdat), .avs_byteenable(4'hf), .avs_readdata(rdat), .avs_waitrequest(wreq),
    .wait_cond_in(cond), .status_bits(st), .micro_program_counter(pc), .bd_wr_strobe(stb),
    .bd_wr_addr(ba), .bd_wr_data(bd));
  task chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks = n_checks + 1;
    if (got !== exp) begin
      err_count = err_count + 1;
      $display("[ERR] %0t got %h want %h", $time, got, exp);
    end
  endtask
  task finish_test;
    if (err_count == 0 && n_checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  // one request held until waitrequest is seen low, then a free cycle
  task bus(input logic w, input logic [7:0] a, input logic [15:0] d);
    integer n;
    n = 0;
    adr <= a;
    wr <= w;
    rd <= !w;
    wdat <= {16'h0, d};
    do begin
      @(posedge clk);
      n = n + 1;
    end while (wreq !== 1'b0 && n < 200);
    if (n >= 200) begin
      err_count = err_count + 1;
      finish_test;
    end
    wr <= 1'b0;
    rd <= 1'b0;
    @(posedge clk);
  endtask
  task rdx(input logic [7:0] a, input logic [31:0] e);
    q.push_back(e);
    bus(1'b0, a, 16'h0);
  endtask
  task subchk(input logic [15:0] a, input logic [15:0] b, input logic [7:0] o);
    s = a - b;
    fl[5:0] = {~a[15] & b[15] & s[15], a[15] & ~b[15] & ~s[15], 1'b0, a < b, s[15], s == 0};
    rdx(o, {16'h0, s});
    rdx(8'h08, {25'h0, fl});
  endtask
  // results are judged in the order the reads were issued
  always @(posedge clk) if (rd && wreq === 1'b0) chk(rdat, q.pop_front());
  always @(posedge clk) if (stb === 1'b1) chk({ba, bd}, bq.pop_front());
  // guard against a hung handshake
  initial begin
    #400000;
    err_count = err_count + 1;
    finish_test;
  end
  initial begin
    k = $urandom(30);
    repeat (10) @(posedge clk);
    rst_b <= 1'b1;
    @(posedge clk);
    s = 16'h0;
    for (i = 0; i < 16; i++) begin
      k = $urandom % 2;
      r1 = s;
      r1[i] = k[0];
      bus(1'b1, 8'h00, 16'h3700 | {11'h0, k[0], i[3:0]});
      s = r1;
      rdx(8'h04, {16'h0, s});
      chk({16'h0, st}, {16'h0, s});
    end
    fl = 7'h0;
    for (i = 0; i < 6; i++) begin
      r1 = $urandom;
      r2 = (i == 0) ? r1 : $urandom;
      k = $urandom % 16;
      bus(1'b1, 8'h44, r1);
      bus(1'b1, 8'h48, r2);
      bus(1'b1, 8'h00, 16'h29d1);
      subchk(r1, r2, 8'h4c);
      bus(1'b1, 8'h00, 16'h1e01 | {9'h0, k[3:0], 3'h0});
      subchk(r1, {12'h0, k[3:0]}, 8'h50);
      bus(1'b1, 8'h00, 16'h3561);
      rdx(8'h44, {16'h0, r1[7:0], r1[15:8]});
      s = $urandom;
      s[15] = i[1];
      bus(1'b1, 8'h54, s);
      bus(1'b1, 8'h00, 16'h3725 | {12'h0, i[0], 3'h0});
      fl[6] = i[0] ? s[15] : fl[6] ^ s[15];
      if (s[15]) s = {1'b0, -s[14:0]};
      rdx(8'h54, {16'h0, s});
      rdx(8'h08, {25'h0, fl});
      bus(1'b1, 8'h00, 16'h3735);
      s = fl[6] ? {1'b1, -s[14:0]} : {1'b0, s[14:0]};
      rdx(8'h54, {16'h0, s});
    end
    for (i = 0; i < 5; i++) begin
      dst[i] = $urandom;
      bus(1'b1, 8'h20 + {3'h0, i[2:0], 2'h0}, {6'h0, dst[i]});
    end
    // all rows, random masks, then a mask of zero that must hang
    for (i = 0; i < 5; i++) begin
      sm = (i == 0) ? 16'h1f : (i == 4) ? 16'h0 : $urandom % 32;
      bus(1'b1, 8'h0c, 16'h0005);
      bus(1'b1, 8'h00, 16'h3500 | {11'h0, sm[4:0]});
      rdx(8'h0c, 32'h5);
      r2 = $urandom;
      r2[4:0] = (i == 4) ? 5'h1f : r2[4:0] | (sm[4:0] & ~(sm[4:0] - 5'h1));
      want <= r2[4:0];
      repeat (5) @(posedge clk);
      r1 = 16'h5;
      for (k = 4; k >= 0; k--) if (sm[k] & r2[k]) r1 = {6'h0, dst[k]};
      rdx(8'h0c, {16'h0, r1});
      chk({22'h0, pc}, {16'h0, r1});
      want <= 5'h0;
      bus(1'b1, 8'h0c, 16'h0);
    end
    for (i = 0; i < 3; i++) begin
      r1 = $urandom;
      r2 = $urandom;
      bus(1'b1, 8'h10, r1);
      bus(1'b1, 8'h14, r2);
      bq.push_back({r1, r2});
      bus(1'b1, 8'h00, 16'h3541);
      bus(1'b1, 8'h10, ~r1);
    end
    repeat (4) @(posedge clk);
    finish_test;
  end
endmodule // mcx_exec_tb
bind mcx_exec mcx_exec_props #(.DW(DW), .PCW(PCW)) prop_u (.clk(clk), .rst_b(rst_b),
  .avs_address(avs_address), .avs_write(avs_write), .avs_writedata(avs_writedata),
  .avs_waitrequest(avs_waitrequest), .status_bits(status_bits),
  .micro_program_counter(micro_program_counter), .bd_wr_strobe(bd_wr_strobe),
  .bd_wr_addr(bd_wr_addr), .bd_wr_data(bd_wr_data));
